// file: include/pcm_pkg.sv
package pcm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 5;        // core_clk at 200 MHz
  localparam int RESET_TIME_NS   = 50000;    // least internal reset cycle
  localparam int MASK_TIME_NS    = 100000;   // full-phase mask timer after voltage_code or deep-sleep change
  // Least time rounds up, longest time rounds down
  localparam int RESET_CYCLES    = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MASK_CYCLES     = MASK_TIME_NS / CLK_PERIOD_NS;
  localparam int MASTER_DIV      = 200;      // core_clk cycles per master clock tick
  localparam int DETECT_TICKS    = 3;        // master ticks spent detecting

  // ----------------------------------------------------------------
  // Widths and encodings
  // ----------------------------------------------------------------
  localparam int CODE_W          = 7;        // voltage_code width
  localparam int PHASES          = 3;
  localparam logic [1:0] CNT_ONE   = 2'h1;
  localparam logic [1:0] CNT_TWO   = 2'h2;
  localparam logic [1:0] CNT_THREE = 2'h3;

  typedef enum logic [1:0] {
    ST_RESET  = 2'b00,   // internal reset cycle, outputs held low
    ST_DETECT = 2'b01,   // pull-down on, sensing phase pins
    ST_RUN    = 2'b10    // normal switching
  } pcm_state_t;
endpackage : pcm_pkg

// file: include/pcm_gen_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcm_gen_if;
  logic       master_tick;     // one-cycle master clock pulse
  logic       run;             // switching allowed
  logic       ripple;          // single-phase ripple mode
  logic [1:0] phase_count;     // latched phases in use
  logic [2:0] pwm_ramp_hit;    // per-phase PWM ramp reached compensation
  logic       comp_upper_hit;  // compensation reached upper limit
  logic       ripple_ramp_hit; // ripple ramp reached compensation
  logic [2:0] pwm;             // registered phase outputs
  logic       ramp_run;        // ripple ramp running

  modport ctl (output master_tick, run, ripple, phase_count, pwm_ramp_hit,
               comp_upper_hit, ripple_ramp_hit, input pwm, ramp_run);
  modport gen (input master_tick, run, ripple, phase_count, pwm_ramp_hit,
               comp_upper_hit, ripple_ramp_hit, output pwm, ramp_run);
endinterface : pcm_gen_if
`default_nettype wire

// file: hdl/pcm_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_phase_gen
  import pcm_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic srst,
  pcm_gen_if.gen    gif
);

  logic [1:0] slot;
  logic [1:0] next_slot;
  logic [2:0] pwm;
  logic [2:0] next_pwm;
  logic       ramp_run;
  logic       next_ramp_run;

  // ----------------------------------------------------------------
  // Phase set and clear
  // ----------------------------------------------------------------
  always_comb begin
    next_slot     = slot;
    next_pwm      = pwm;
    next_ramp_run = 1'b0;
    if (!gif.run) begin
      next_slot = 2'h0;
      next_pwm  = 3'h0;
    end else if (gif.ripple) begin
      next_pwm[0]   = pwm[0] ? !gif.ripple_ramp_hit : gif.comp_upper_hit;
      next_pwm[2:1] = 2'h0;
      next_ramp_run = next_pwm[0];
      next_slot     = 2'h0;
    end else begin
      // rotate slot over phases in use
      if (gif.master_tick) begin
        next_slot = (slot + 2'h1 >= gif.phase_count) ? 2'h0 : slot + 2'h1;
      end
      for (int i = 0; i < PHASES; i++) begin
        if (gif.master_tick && slot == 2'(i) && 2'(i) < gif.phase_count) begin
          next_pwm[i] = 1'b1;
        end else if (gif.pwm_ramp_hit[i] || 2'(i) >= gif.phase_count) begin
          next_pwm[i] = 1'b0;
        end
      end
    end
  end

  // Registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      slot     <= 2'h0;
      pwm      <= 3'h0;
      ramp_run <= 1'b0;
    end else begin
      slot     <= next_slot;
      pwm      <= next_pwm;
      ramp_run <= next_ramp_run;
    end
  end

  assign gif.pwm      = pwm;
  assign gif.ramp_run = ramp_run;

endmodule : pcm_phase_gen
`default_nettype wire

// file: hdl/pcm_top.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_top
  import pcm_pkg::*;
#(
  parameter int RESET_CNT  = RESET_CYCLES,
  parameter int MASK_CNT   = MASK_CYCLES,
  parameter int MASTER_CNT = MASTER_DIV
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              power_state_in,
  input  wire logic              deep_sleep_in,
  input  wire logic [CODE_W-1:0] voltage_code,
  input  wire logic              current_limit_in,
  input  wire logic [2:0]        pwm_ramp_hit,
  input  wire logic              comp_upper_hit,
  input  wire logic              ripple_ramp_hit,
  input  wire logic              phase_two_in,
  input  wire logic              phase_three_in,
  output logic                   phase_one_out,
  output logic                   phase_two_out,
  output logic                   phase_two_oe_n,
  output logic                   phase_three_out,
  output logic                   phase_three_oe_n,
  output logic                   pull_down_en,
  output logic                   ramp_run,
  output logic                   ripple_mode,
  output logic                   discontinuous_mode_out,
  output logic                   full_phase,
  output logic [1:0]             phase_count
);

  localparam int RW = $clog2(RESET_CNT + 1);
  localparam int MW = $clog2(MASK_CNT + 1);
  localparam int DW = $clog2(MASTER_CNT);

  pcm_state_t        state;
  pcm_state_t        next_state;
  logic [RW-1:0]     rst_cnt;
  logic [RW-1:0]     next_rst_cnt;
  logic [1:0]        det_ticks;
  logic [1:0]        next_det_ticks;
  logic [1:0]        next_phase_count;
  logic              next_pull_down_en;
  logic              next_phase_two_oe_n;
  logic              next_phase_three_oe_n;
  logic [DW-1:0]     div_cnt;
  logic [DW-1:0]     next_div_cnt;
  logic              master_tick;
  logic [MW-1:0]     mask_cnt;
  logic [MW-1:0]     next_mask_cnt;
  logic [CODE_W-1:0] code_q;
  logic              sleep_q;
  logic              next_full_phase;
  logic              next_ripple_mode;
  logic              next_dcm;

  pcm_gen_if gif ();

  // ----------------------------------------------------------------
  // Master clock divider
  // ----------------------------------------------------------------
  always_comb begin
    master_tick  = (div_cnt == DW'(MASTER_CNT - 1));
    next_div_cnt = master_tick ? '0 : div_cnt + DW'(1);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Reset cycle and phase detection
  // ----------------------------------------------------------------
  always_comb begin
    next_state            = state;
    next_rst_cnt          = rst_cnt;
    next_det_ticks        = det_ticks;
    next_phase_count      = phase_count;
    next_pull_down_en     = 1'b0;
    next_phase_two_oe_n   = phase_two_oe_n;
    next_phase_three_oe_n = phase_three_oe_n;
    case (state)
      ST_RESET: begin
        next_rst_cnt = rst_cnt + RW'(1);
        if (rst_cnt == RW'(RESET_CNT - 1)) begin
          next_state            = ST_DETECT;
          next_det_ticks        = 2'h0;
          next_pull_down_en     = 1'b1;
          next_phase_two_oe_n   = 1'b1;
          next_phase_three_oe_n = 1'b1;
        end
      end
      ST_DETECT: begin
        next_pull_down_en = 1'b1;
        if (master_tick) begin
          next_det_ticks = det_ticks + 2'h1;
          if (det_ticks == 2'(DETECT_TICKS - 1)) begin
            next_state        = ST_RUN;
            next_pull_down_en = 1'b0;
            if (phase_two_in) begin
              next_phase_count = CNT_ONE;
            end else if (phase_three_in) begin
              next_phase_count = CNT_TWO;
            end else begin
              next_phase_count = CNT_THREE;
            end
            next_phase_two_oe_n   = phase_two_in;
            next_phase_three_oe_n = phase_two_in | phase_three_in;
          end
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state            <= ST_RESET;
      rst_cnt          <= '0;
      det_ticks        <= 2'h0;
      phase_count      <= CNT_THREE;
      pull_down_en     <= 1'b0;
      phase_two_oe_n   <= 1'b0;
      phase_three_oe_n <= 1'b0;
    end else begin
      state            <= next_state;
      rst_cnt          <= next_rst_cnt;
      det_ticks        <= next_det_ticks;
      phase_count      <= next_phase_count;
      pull_down_en     <= next_pull_down_en;
      phase_two_oe_n   <= next_phase_two_oe_n;
      phase_three_oe_n <= next_phase_three_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // Transient timer and mode select
  // ----------------------------------------------------------------
  always_comb begin
    next_mask_cnt = (mask_cnt != '0) ? mask_cnt - MW'(1) : '0;
    if (voltage_code != code_q || deep_sleep_in != sleep_q) begin
      next_mask_cnt = MW'(MASK_CNT);
    end
    next_full_phase  = (next_mask_cnt != '0) || current_limit_in ||
                       (power_state_in && !deep_sleep_in);
    next_ripple_mode = !next_full_phase;
    next_dcm         = !next_full_phase && deep_sleep_in;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mask_cnt               <= '0;
      code_q                 <= '0;
      sleep_q                <= 1'b0;
      full_phase             <= 1'b1;
      ripple_mode            <= 1'b0;
      discontinuous_mode_out <= 1'b0;
    end else begin
      mask_cnt               <= next_mask_cnt;
      code_q                 <= voltage_code;
      sleep_q                <= deep_sleep_in;
      full_phase             <= next_full_phase;
      ripple_mode            <= next_ripple_mode;
      discontinuous_mode_out <= next_dcm;
    end
  end

  // ----------------------------------------------------------------
  // Phase generator
  // ----------------------------------------------------------------
  assign gif.master_tick     = master_tick;
  assign gif.run             = (state == ST_RUN);
  assign gif.ripple          = ripple_mode;
  assign gif.phase_count     = phase_count;
  assign gif.pwm_ramp_hit    = pwm_ramp_hit;
  assign gif.comp_upper_hit  = comp_upper_hit;
  assign gif.ripple_ramp_hit = ripple_ramp_hit;

  pcm_phase_gen u_gen (
    .core_clk (core_clk),
    .srst     (srst),
    .gif      (gif)
  );

  // Outputs straight from generator flops
  assign phase_one_out   = gif.pwm[0];
  assign phase_two_out   = gif.pwm[1];
  assign phase_three_out = gif.pwm[2];
  assign ramp_run        = gif.ramp_run;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int DET_MAX = 3 * MASTER_CNT + 2;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_idle_low: assert property (state != ST_RUN |=> !phase_one_out && !phase_two_out)
    else $error("phase output high before run");
  a_three_default: assert property (state == ST_DETECT && next_state == ST_RUN
      && !phase_two_in && !phase_three_in |=> phase_count == CNT_THREE)
    else $error("three phases not selected");
  a_pull_detect: assert property ($rose(state == ST_DETECT) |-> pull_down_en && phase_two_oe_n)
    else $error("no pull-down during detection");
  a_detect_len: assert property ($rose(state == ST_DETECT) |-> ##[1:DET_MAX] state == ST_RUN)
    else $error("detection too long");
  a_pull_off: assert property (state == ST_RUN |-> !pull_down_en
      && (phase_three_oe_n == (phase_count != CNT_THREE)))
    else $error("pull-down or enable wrong in run");
  a_single_only: assert property (ripple_mode |=> !phase_two_out && !phase_three_out)
    else $error("upper phase switching in ripple mode");
  a_ripple_set: assert property (state == ST_RUN && ripple_mode && !phase_one_out
      && comp_upper_hit |=> phase_one_out && ramp_run)
    else $error("ripple pulse not started");
  a_ripple_clr: assert property (ripple_mode && phase_one_out && ripple_ramp_hit
      |=> !phase_one_out)
    else $error("ripple pulse not ended");
  a_dcm_sleep: assert property (discontinuous_mode_out |-> ripple_mode && $past(deep_sleep_in))
    else $error("discontinuous outside deep-sleep ripple");
  a_code_full: assert property (voltage_code != $past(voltage_code) |=> full_phase [*8])
    else $error("code change did not force full mode");
  a_count_held: assert property (state == ST_RUN && $past(state) == ST_RUN |-> $stable(phase_count))
    else $error("phase count changed in run");

  c_three_run: cover property (state == ST_RUN && phase_count == CNT_THREE && phase_three_out);
  c_ripple_pulse: cover property (ripple_mode && $fell(phase_one_out));
  c_dcm_on: cover property ($rose(discontinuous_mode_out));

endmodule : pcm_top
`default_nettype wire

// file: verif/pcm_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_board_model (
  input  wire logic       core_clk,
  input  wire logic       tie_two,
  input  wire logic       tie_three,
  input  wire logic [7:0] duty,
  input  wire logic       phase_one_out,
  input  wire logic       phase_two_out,
  input  wire logic       phase_two_oe_n,
  input  wire logic       phase_three_out,
  input  wire logic       phase_three_oe_n,
  input  wire logic       pull_down_en,
  input  wire logic       ramp_run,
  output logic            phase_two_in,
  output logic            phase_three_in,
  output logic [2:0]      pwm_ramp_hit,
  output logic            ripple_ramp_hit
);
  logic [7:0] on_time [0:3] = '{default: 8'h00};
  logic       flick = 1'b0;
  logic [3:0] hi;
  logic [3:0] hit = 4'h0;

  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // board tie-high
  always_comb begin
    hi = {ramp_run, phase_three_out, phase_two_out, phase_one_out};
    phase_two_in   = tie_two | (!phase_two_oe_n ? phase_two_out : (!pull_down_en & flick));
    phase_three_in = tie_three | (!phase_three_oe_n ? phase_three_out : (!pull_down_en & flick));
    pwm_ramp_hit   = hit[2:0];
    ripple_ramp_hit = hit[3];
  end

  // ----------------------------------------------------------------
  // Ramps end duty cycles after turn-on
  // ----------------------------------------------------------------
  always @(negedge core_clk) begin
    flick <= ~flick;
    for (int i = 0; i < 4; i++) begin
      on_time[i] <= hi[i] ? on_time[i] + 8'h01 : 8'h00;
      hit[i]     <= hi[i] && (on_time[i] >= duty) && (i == 3 || !ramp_run);
    end
  end
endmodule : pcm_board_model
`default_nettype wire

// file: verif/phase_count_and_mode_select_test.sv
`timescale 1ns/1ps
`default_nettype none
module phase_count_and_mode_select_test;
  import pcm_pkg::*;
  localparam int RST_N = 20;
  localparam int MASK_N = 30;
  localparam int TICK_N = 4;
  logic              core_clk = 1'b0;
  logic              srst = 1'b1;
  logic              power_state_in = 1'b1;
  logic              deep_sleep_in = 1'b0;
  logic [CODE_W-1:0] voltage_code = 7'h10;
  logic              current_limit_in = 1'b0;
  logic              comp_upper_hit = 1'b0;
  logic              tie_two = 1'b0;
  logic              tie_three = 1'b0;
  logic [7:0]        duty = 8'h01;
  logic [2:0]        pwm_ramp_hit;
  logic              ripple_ramp_hit, phase_two_in, phase_three_in;
  logic              phase_one_out, phase_two_out, phase_two_oe_n, phase_three_out, phase_three_oe_n;
  logic              pull_down_en, ramp_run, ripple_mode, discontinuous_mode_out, full_phase;
  logic [1:0]        phase_count;
  int                bad_count = 0;
  int                n_compared = 0;

  always #2.5 core_clk = ~core_clk;

  pcm_top #(.RESET_CNT(RST_N), .MASK_CNT(MASK_N), .MASTER_CNT(TICK_N)) i_dut (
    .core_clk(core_clk), .srst(srst), .power_state_in(power_state_in), .deep_sleep_in(deep_sleep_in),
    .voltage_code(voltage_code), .current_limit_in(current_limit_in), .pwm_ramp_hit(pwm_ramp_hit),
    .comp_upper_hit(comp_upper_hit), .ripple_ramp_hit(ripple_ramp_hit), .phase_two_in(phase_two_in),
    .phase_three_in(phase_three_in), .phase_one_out(phase_one_out), .phase_two_out(phase_two_out),
    .phase_two_oe_n(phase_two_oe_n), .phase_three_out(phase_three_out),
    .phase_three_oe_n(phase_three_oe_n), .pull_down_en(pull_down_en), .ramp_run(ramp_run),
    .ripple_mode(ripple_mode), .discontinuous_mode_out(discontinuous_mode_out),
    .full_phase(full_phase), .phase_count(phase_count));

  pcm_board_model i_board (
    .core_clk(core_clk), .tie_two(tie_two), .tie_three(tie_three), .duty(duty),
    .phase_one_out(phase_one_out), .phase_two_out(phase_two_out), .phase_two_oe_n(phase_two_oe_n),
    .phase_three_out(phase_three_out), .phase_three_oe_n(phase_three_oe_n),
    .pull_down_en(pull_down_en), .ramp_run(ramp_run), .phase_two_in(phase_two_in),
    .phase_three_in(phase_three_in), .pwm_ramp_hit(pwm_ramp_hit), .ripple_ramp_hit(ripple_ramp_hit));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Length of forced full-phase mode after a trigger
  task automatic mask_len;
    int k;
    repeat (2) @(negedge core_clk);
    check({full_phase, ripple_mode, discontinuous_mode_out}, 3'h4);
    for (k = 2; k < MASK_N + 10 && full_phase === 1'b1; k++) @(negedge core_clk);
    check(k >= MASK_N - 2 && k <= MASK_N + 3, 1'b1);
  endtask : mask_len

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic run_reset(input logic t2, input logic t3, input logic [1:0] cnt);
    int k;
    tie_two = t2;
    tie_three = t3;
    srst = 1'b1;
    repeat (20) @(negedge core_clk);
    check({phase_one_out, phase_two_out, phase_three_out, pull_down_en}, 4'h0);
    srst = 1'b0;
    for (k = 0; k < RST_N + 4 && pull_down_en !== 1'b1; k++) @(negedge core_clk);
    check(k >= RST_N && k <= RST_N + 1, 1'b1);
    check({phase_two_oe_n, phase_three_oe_n, phase_one_out}, 3'h6);
    for (k = 0; k < 4 * TICK_N && pull_down_en !== 1'b0; k++) @(negedge core_clk);
    check(k <= 3 * TICK_N, 1'b1);
    check(phase_count, cnt);
    check({phase_two_oe_n, phase_three_oe_n}, {t2, t3});
  endtask : run_reset

  task automatic freq_check(input logic [1:0] cnt, input logic [7:0] d, input logic want_overlap);
    logic [2:0] prev, now;
    int         rises [3];
    int         i, overlap;
    rises = '{0, 0, 0};
    overlap = 0;
    duty = d;
    tie_two = ~tie_two;
    tie_three = ~tie_three;
    repeat (MASK_N + 5) @(negedge core_clk);
    check({full_phase, ripple_mode, discontinuous_mode_out}, 3'h4);
    prev = {phase_three_out, phase_two_out, phase_one_out};
    repeat (4 * cnt * TICK_N) begin
      @(negedge core_clk);
      now = {phase_three_out, phase_two_out, phase_one_out};
      for (i = 0; i < 3; i++) if (now[i] && !prev[i]) rises[i]++;
      if ($countones(now) > 1) overlap++;
      prev = now;
    end
    for (i = 0; i < 3; i++) check(8'(rises[i]), (i < cnt) ? 8'h04 : 8'h00);
    if (want_overlap) check(overlap > 0, 1'b1);
    check(phase_count, cnt);
  endtask : freq_check

  task automatic ripple_check;
    int k, n;
    duty = 8'h03;
    power_state_in = 1'b0;
    repeat (4) @(negedge core_clk);
    check({full_phase, ripple_mode, discontinuous_mode_out}, 3'h2);
    repeat (3 * TICK_N) @(negedge core_clk);
    check({phase_one_out, phase_two_out, phase_three_out}, 3'h0);
    for (n = 0; n < 2; n++) begin
      comp_upper_hit = 1'b1;
      @(negedge core_clk);
      comp_upper_hit = 1'b0;
      check({phase_one_out, ramp_run}, 2'h3);
      for (k = 0; k < 10 && phase_one_out === 1'b1; k++) @(negedge core_clk);
      check(k >= 3 && k <= 6, 1'b1);
      check({ramp_run, phase_two_out, phase_three_out}, 3'h0);
    end
  endtask : ripple_check

  task automatic event_check;
    deep_sleep_in = 1'b1;
    mask_len;
    check({ripple_mode, discontinuous_mode_out}, 2'h3);
    voltage_code = 7'h2b;
    mask_len;
    current_limit_in = 1'b1;
    repeat (2) @(negedge core_clk);
    check({full_phase, ripple_mode, discontinuous_mode_out}, 3'h4);
    current_limit_in = 1'b0;
    repeat (3) @(negedge core_clk);
    check({full_phase, ripple_mode}, 2'h1);
    // Deep-sleep exit with power-state low: forced full, then continuous ripple
    deep_sleep_in = 1'b0;
    mask_len;
    check({full_phase, ripple_mode, discontinuous_mode_out}, 3'h2);
    power_state_in = 1'b1;
    repeat (2) @(negedge core_clk);
    check({full_phase, ripple_mode, discontinuous_mode_out}, 3'h4);
  endtask : event_check

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    run_reset(1'b0, 1'b0, CNT_THREE);
    freq_check(CNT_THREE, 8'h06, 1'b1);
    run_reset(1'b0, 1'b1, CNT_TWO);
    freq_check(CNT_TWO, 8'h01, 1'b0);
    run_reset(1'b1, 1'b1, CNT_ONE);
    freq_check(CNT_ONE, 8'h01, 1'b0);
    run_reset(1'b0, 1'b0, CNT_THREE);
    ripple_check;
    event_check;
    report_and_stop;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    report_and_stop;
  end
endmodule : phase_count_and_mode_select_test
`default_nettype wire
